// *** hw/pms_seq.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "pms_params.svh"
module pms_seq import pms_pkg::*; #(
    parameter int PG_WAIT_CYCLES = `PMS_PG_WAIT_MS * `PMS_CLK_KHZ,
    parameter int SCAN_DWELL     = `PMS_SCAN_DWELL
) (
    // Clock, reset, enable
    input  wire logic        i_mclk,
    input  wire logic        i_reset_n,
    input  wire logic        i_ce,
    // Host writes to the two output ports
    input  wire logic        i_host_wr_low,
    input  wire logic        i_host_wr_high,
    input  wire logic [7:0]  i_host_wr_data,
    // Wake events
    input  wire logic        i_dma_req_unmasked,
    input  wire logic        i_irq_unmasked,
    input  wire logic        i_nmi_unmasked,
    // Processor levels from system logic
    input  wire logic        i_processor_clock,
    input  wire logic        i_ready,
    input  wire logic        i_hold,
    input  wire logic        i_interrupt_request,
    input  wire logic        i_nmi,
    input  wire logic        i_gate_a20,
    input  wire logic        i_hlda,
    // Arbitration
    input  wire logic        i_refresh_busy,
    input  wire logic        i_dma_busy,
    input  wire logic        i_master_busy,
    // Configuration
    input  wire logic        i_local_request_enable,
    input  wire logic        i_output_update_enable,
    // External latch, mux and keyboard bus
    input  wire logic        i_power_serial_input,
    output logic      [2:0]  o_mux_select,
    input  wire logic [7:0]  i_expansion_data_bus_in,
    output logic      [7:0]  o_expansion_data_bus_out,
    output logic             o_expansion_data_bus_oe,
    output logic      [4:0]  o_chip_select_code,
    output logic             o_data_high_enable_n,
    output logic             o_data_low_enable_n,
    // Processor outputs
    output logic             o_processor_reset_out,
    output logic             o_processor_reset_oe,
    output logic             o_processor_clock_out,
    output logic             o_ready,
    output logic             o_hold,
    output logic             o_interrupt_request_out,
    output logic             o_nmi,
    // Internal register access
    output pms_req_type      o_reg_req,
    input  wire logic [15:0] i_reg_rdata,
    // Status
    output logic      [15:0] o_pmc_outputs,
    output logic      [7:0]  o_pmc_inputs,
    output logic             o_powered_down
);
    if (PG_WAIT_CYCLES < 1 || PG_WAIT_CYCLES > 1048576) begin : g_chk
        $error("pms_seq: PG_WAIT_CYCLES out of range");
    end

    localparam logic [19:0] PG_LAST  = 20'(PG_WAIT_CYCLES - 1);
    localparam logic [19:0] PD_LAST  = 20'(`PMS_ASSERT_CYC - 1);
    localparam logic [6:0]  RST_LAST = 7'(`PMS_RESET_CLKS - 1);
    localparam logic [3:0]  PH_LAST  = 4'(`PMS_PHASE_CYC - 1);

    // Processor held in reset while the device itself is in reset
    localparam pms_state_type ST_RESET = '{
        pwr:     P_RUN,
        lcl:     L_IDLE,
        pmc_out: `PMS_OUT_RESET,
        cs:      `PMS_CS_NONE,
        hi_en_n: 1'b1,
        lo_en_n: 1'b1,
        rst_out: 1'b1,
        rst_oe:  1'b1,
        default: '0
    };

    pms_state_type r_reg;
    pms_state_type r_next;

    logic [9:0] pins_sync;
    logic [7:0] bus_in_s;
    logic       hlda_s;
    logic [7:0] scan_in;
    logic       lreq;
    logic       pwr_good;
    logic       wake;
    logic       clk_rise;
    logic       parked;
    logic       host_wr;
    logic       bus_free;
    logic [7:0] cur_low;

    // ****************************************************************
    // Pin synchronisers and input mux scan
    // ****************************************************************
    pms_sync u_sync (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_ce      (i_ce),
        .i_async   ({i_expansion_data_bus_in, i_hlda, i_power_serial_input}),
        .o_sync    (pins_sync)
    );

    pms_mux_scan #(
        .DWELL (SCAN_DWELL)
    ) u_scan (
        .i_mclk        (i_mclk),
        .i_reset_n     (i_reset_n),
        .i_ce          (i_ce),
        .i_serial_sync (pins_sync[0]),
        .o_mux_select  (o_mux_select),
        .o_pmc_inputs  (scan_in)
    );

    // Latch byte: bit 6 follows the internal a20 gate
    function automatic logic [7:0] low_byte(input logic [7:0] o, input logic a20);
        return {o[7], a20, o[5:0]};
    endfunction

    assign bus_in_s = pins_sync[9:2];
    assign hlda_s   = pins_sync[1];
    assign lreq     = i_local_request_enable && scan_in[`PMS_IN_LCLREQ];
    assign pwr_good = scan_in[`PMS_IN_PWRGOOD];
    assign wake     = i_dma_req_unmasked || i_irq_unmasked || i_nmi_unmasked;
    assign clk_rise = i_processor_clock && !r_reg.clk_prev;
    assign parked   = r_reg.pwr inside {P_ASSERT, P_FLOAT, P_WAIT};
    assign host_wr  = i_host_wr_low || i_host_wr_high;
    assign cur_low  = low_byte(r_reg.pmc_out[7:0], i_gate_a20);

    always_comb begin
        r_next                 = r_reg;
        r_next.req.valid       = 1'b0;
        r_next.req.bypass_lock = 1'b1;
        r_next.clk_prev        = i_processor_clock;
        r_next.low_seen        = cur_low;
        r_next.bus_oe          = 1'b0;
        r_next.cs              = `PMS_CS_NONE;
        bus_free               = 1'b0;

        // Grant bit 3 belongs to the local access logic
        if (i_host_wr_low) begin
            r_next.pmc_out[7:0]        = i_host_wr_data;
            r_next.pmc_out[`PMS_BIT_ACK] = r_reg.pmc_out[`PMS_BIT_ACK];
        end
        if (i_host_wr_high) begin
            r_next.pmc_out[15:8] = i_host_wr_data;
        end
        if (r_reg.req.valid && !r_reg.req.write) begin
            r_next.data = i_reg_rdata;
        end

        // ************************************************************
        // Power down and power up sequence
        // ************************************************************
        unique case (r_reg.pwr)
            P_RUN: begin
                if (host_wr && r_next.pmc_out[`PMS_BIT_PWRDN]) begin
                    r_next.pwr = P_ASSERT;
                    r_next.cnt = '0;
                end
            end
            P_ASSERT: begin
                r_next.cnt = r_reg.cnt + 20'h1;
                if (r_reg.cnt == PD_LAST) begin
                    r_next.pwr = P_FLOAT;
                end
            end
            P_FLOAT: begin
                if (wake) begin
                    r_next.pwr                     = P_WAIT;
                    r_next.cnt                     = '0;
                    r_next.pmc_out[`PMS_BIT_PWRDN] = 1'b0;
                end
            end
            P_WAIT: begin
                r_next.cnt = r_reg.cnt + 20'h1;
                if (r_reg.cnt == PG_LAST) begin
                    r_next.cnt = '0;
                    if (pwr_good) begin
                        r_next.pwr     = P_RESET;
                        r_next.clk_cnt = '0;
                    end
                end
            end
            P_RESET: begin
                if (clk_rise) begin
                    r_next.clk_cnt = r_reg.clk_cnt + 7'h1;
                    if (r_reg.clk_cnt == RST_LAST) begin
                        r_next.pwr = P_RUN;
                    end
                end
            end
            default: r_next.pwr = P_RUN;
        endcase

        // ************************************************************
        // Keyboard local register access
        // ************************************************************
        unique case (r_reg.lcl)
            L_IDLE: begin
                if (lreq && r_reg.pwr == P_RUN) begin
                    r_next.lcl = L_HOLD;
                end
            end
            L_HOLD: begin
                if (!i_refresh_busy && !i_dma_busy && !i_master_busy) begin
                    r_next.hold_req = 1'b1;
                end
                if (r_reg.hold_req && hlda_s) begin
                    r_next.pmc_out[`PMS_BIT_ACK] = 1'b1;
                    r_next.lcl                   = L_ACK;
                end
            end
            L_ACK: begin
                if (!lreq) begin
                    r_next.opcode                = bus_in_s;
                    r_next.pmc_out[`PMS_BIT_ACK] = 1'b0;
                    r_next.phase                 = '0;
                    r_next.lcl                   = L_HI;
                    if (!bus_in_s[`PMS_OP_WRITE]) begin
                        r_next.req.valid = 1'b1;
                        r_next.req.write = 1'b0;
                        r_next.req.addr  = bus_in_s[6:0];
                    end
                end
            end
            L_HI: begin
                r_next.phase = r_reg.phase + 4'h1;
                if (r_reg.phase == PH_LAST) begin
                    r_next.phase = '0;
                    r_next.lcl   = L_LO;
                    if (r_reg.opcode[`PMS_OP_WRITE]) begin
                        r_next.data[15:8] = bus_in_s;
                    end
                end
            end
            L_LO: begin
                r_next.phase = r_reg.phase + 4'h1;
                if (r_reg.phase == PH_LAST) begin
                    r_next.lcl      = L_DONE;
                    r_next.hold_req = 1'b0;
                    if (r_reg.opcode[`PMS_OP_WRITE]) begin
                        r_next.data[7:0] = bus_in_s;
                        r_next.req.valid = 1'b1;
                        r_next.req.write = 1'b1;
                        r_next.req.addr  = r_reg.opcode[6:0];
                        r_next.req.wdata = {r_reg.data[15:8], bus_in_s};
                    end
                end
            end
            L_DONE: begin
                if (!hlda_s) begin
                    r_next.lcl = L_IDLE;
                end
            end
            default: r_next.lcl = L_IDLE;
        endcase

        // ************************************************************
        // Expansion bus: read data or latch update strobes
        // ************************************************************
        r_next.hi_en_n = (r_next.lcl != L_HI);
        r_next.lo_en_n = (r_next.lcl != L_LO);
        if (r_next.lcl inside {L_HI, L_LO}) begin
            if (!r_next.opcode[`PMS_OP_WRITE]) begin
                r_next.bus_oe  = 1'b1;
                r_next.bus_out = (r_next.lcl == L_HI) ? r_next.data[15:8]
                                                      : r_next.data[7:0];
            end
        end else begin
            bus_free = 1'b1;
        end
        if (bus_free && r_reg.upd_low) begin
            r_next.bus_oe  = 1'b1;
            r_next.bus_out = cur_low;
            r_next.cs      = `PMS_CS_OUT_LOW;
            r_next.upd_low = 1'b0;
        end else if (bus_free && r_reg.upd_high) begin
            r_next.bus_oe   = 1'b1;
            r_next.bus_out  = r_reg.pmc_out[15:8];
            r_next.cs       = `PMS_CS_OUT_HIGH;
            r_next.upd_high = 1'b0;
        end
        // A new trigger wins over the clear above
        if (i_host_wr_low || (i_output_update_enable && cur_low != r_reg.low_seen)) begin
            r_next.upd_low = 1'b1;
        end
        if (i_host_wr_high) begin
            r_next.upd_high = 1'b1;
        end

        // ************************************************************
        // Processor pins
        // ************************************************************
        r_next.cpu_clk = !parked && i_processor_clock;
        r_next.ready   = !parked && i_ready;
        r_next.hold    = !parked && (i_hold || r_reg.hold_req);
        r_next.interrupt_request_out   = !parked && i_interrupt_request;
        r_next.nmi     = !parked && i_nmi;
        // Pull-up keeps reset active while floating
        r_next.rst_oe  = !(r_next.pwr inside {P_FLOAT, P_WAIT});
        r_next.rst_out = r_next.pwr inside {P_ASSERT, P_RESET};
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            r_reg <= ST_RESET;
        end else if (i_ce) begin
            r_reg <= r_next;
        end
    end

    assign o_expansion_data_bus_out = r_reg.bus_out;
    assign o_expansion_data_bus_oe  = r_reg.bus_oe;
    assign o_chip_select_code       = r_reg.cs;
    assign o_data_high_enable_n     = r_reg.hi_en_n;
    assign o_data_low_enable_n      = r_reg.lo_en_n;
    assign o_processor_reset_out    = r_reg.rst_out;
    assign o_processor_reset_oe     = r_reg.rst_oe;
    assign o_processor_clock_out    = r_reg.cpu_clk;
    assign o_ready                  = r_reg.ready;
    assign o_hold                   = r_reg.hold;
    assign o_interrupt_request_out  = r_reg.interrupt_request_out;
    assign o_nmi                    = r_reg.nmi;
    assign o_reg_req                = r_reg.req;
    assign o_pmc_outputs            = r_reg.pmc_out;
    assign o_pmc_inputs             = scan_in;
    assign o_powered_down           = parked;

    // ****************************************************************
    // Checks
    // ****************************************************************
    pd_start_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n || !i_ce)
        r_reg.pwr == P_RUN && i_host_wr_low && i_host_wr_data[`PMS_BIT_PWRDN]
        |=> r_reg.pwr == P_ASSERT && o_processor_reset_out && o_processor_reset_oe)
        else $error("power down did not start");
    reset_float_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n || !i_ce)
        $rose(r_reg.pwr == P_FLOAT) |-> !o_processor_reset_oe && $past(o_processor_reset_out))
        else $error("reset not asserted before float");
    park_outputs_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n || !i_ce)
        parked |=> !o_processor_clock_out && !o_ready && !o_hold
                   && !o_interrupt_request_out && !o_nmi)
        else $error("processor outputs not parked");
    wake_clear_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n || !i_ce)
        r_reg.pwr == P_FLOAT && wake
        |=> r_reg.pwr == P_WAIT && !o_pmc_outputs[`PMS_BIT_PWRDN])
        else $error("wake event lost");
    pg_retry_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n || !i_ce)
        r_reg.pwr == P_WAIT && r_reg.cnt == PG_LAST && !pwr_good
        |=> r_reg.pwr == P_WAIT && r_reg.cnt == 20'h0)
        else $error("power up without power good");
    pg_restore_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n || !i_ce)
        r_reg.pwr == P_WAIT && r_reg.cnt == PG_LAST && pwr_good
        |=> r_reg.pwr == P_RESET && o_processor_reset_out && o_processor_reset_oe)
        else $error("reset not driven high at power good");
    reset_count_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n || !i_ce)
        $fell(r_reg.pwr == P_RESET) |-> $past(r_reg.clk_cnt) == RST_LAST
                                        && !o_processor_reset_out)
        else $error("reset released early");
    grant_set_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n || !i_ce)
        r_reg.lcl == L_HOLD && r_reg.hold_req && hlda_s
        |=> o_pmc_outputs[`PMS_BIT_ACK] ##2 o_chip_select_code == `PMS_CS_OUT_LOW)
        else $error("grant not latched");
    grant_drop_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n || !i_ce)
        r_reg.lcl == L_ACK && !lreq |=> !o_pmc_outputs[`PMS_BIT_ACK] && !o_data_high_enable_n)
        else $error("grant not removed");
    strobe_code_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n || !i_ce)
        o_chip_select_code != `PMS_CS_NONE |-> o_expansion_data_bus_oe
        && (o_chip_select_code == `PMS_CS_OUT_LOW || o_chip_select_code == `PMS_CS_OUT_HIGH))
        else $error("bad strobe code");
endmodule
`default_nettype wire

// *** hw/pms_params.svh ***
`ifndef PMS_PARAMS_SVH
`define PMS_PARAMS_SVH

`define PMS_OUT_RESET   16'h0000
`define PMS_BIT_ACK     3
`define PMS_BIT_PWRDN   5
`define PMS_IN_PWRGOOD  1
`define PMS_IN_LCLREQ   2
`define PMS_OP_WRITE    7
`define PMS_CS_OUT_LOW  5'h03
`define PMS_CS_OUT_HIGH 5'h17
`define PMS_CS_NONE     5'h1F
`define PMS_PG_WAIT_MS  1
`define PMS_CLK_KHZ     125000
`define PMS_RESET_CLKS  64
`define PMS_ASSERT_CYC  4
`define PMS_PHASE_CYC   8
`define PMS_SCAN_DWELL  4
`define PMS_SYNC_W      10
`endif

// *** hw/pms_pkg.sv ***
package pms_pkg;
    typedef enum logic [4:0] {
        P_RUN    = 5'h01,
        P_ASSERT = 5'h02,
        P_FLOAT  = 5'h04,
        P_WAIT   = 5'h08,
        P_RESET  = 5'h10
    } pms_pwr_type;

    typedef enum logic [5:0] {
        L_IDLE = 6'h01,
        L_HOLD = 6'h02,
        L_ACK  = 6'h04,
        L_HI   = 6'h08,
        L_LO   = 6'h10,
        L_DONE = 6'h20
    } pms_lcl_type;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [6:0]  addr;
        logic [15:0] wdata;
        logic        bypass_lock;
    } pms_req_type;

    typedef struct packed {
        logic [9:0] s2;
        logic [9:0] s1;
    } pms_sync_type;

    typedef struct packed {
        logic [2:0] sel;
        logic [3:0] dwell;
        logic [7:0] inputs;
    } pms_scan_type;

    typedef struct packed {
        pms_pwr_type pwr;
        pms_lcl_type lcl;
        logic [15:0] pmc_out;
        logic [7:0]  low_seen;
        logic        upd_low;
        logic        upd_high;
        logic [19:0] cnt;
        logic [6:0]  clk_cnt;
        logic        clk_prev;
        logic        hold_req;
        logic [7:0]  opcode;
        logic [15:0] data;
        logic [3:0]  phase;
        logic [7:0]  bus_out;
        logic        bus_oe;
        logic [4:0]  cs;
        logic        hi_en_n;
        logic        lo_en_n;
        pms_req_type req;
        logic        cpu_clk;
        logic        ready;
        logic        hold;
        logic        interrupt_request_out;
        logic        nmi;
        logic        rst_out;
        logic        rst_oe;
    } pms_state_type;
endpackage

// *** hw/pms_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "pms_params.svh"
module pms_sync import pms_pkg::*; (
    // Clock, reset, enable
    input  wire logic                   i_mclk,
    input  wire logic                   i_reset_n,
    input  wire logic                   i_ce,
    // Pins in, synchronised out
    input  wire logic [`PMS_SYNC_W-1:0] i_async,
    output logic      [`PMS_SYNC_W-1:0] o_sync
);
    pms_sync_type r_reg;
    pms_sync_type r_next;

    always_comb begin
        r_next    = r_reg;
        r_next.s1 = i_async;
        r_next.s2 = r_reg.s1;
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            r_reg <= '0;
        end else if (i_ce) begin
            r_reg <= r_next;
        end
    end

    assign o_sync = r_reg.s2;
endmodule
`default_nettype wire

// *** hw/pms_mux_scan.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "pms_params.svh"
module pms_mux_scan import pms_pkg::*; #(
    parameter int DWELL = `PMS_SCAN_DWELL
) (
    // Clock, reset, enable
    input  wire logic       i_mclk,
    input  wire logic       i_reset_n,
    input  wire logic       i_ce,
    // Synchronised mux output, select pins
    input  wire logic       i_serial_sync,
    output logic      [2:0] o_mux_select,
    // Input register
    output logic      [7:0] o_pmc_inputs
);
    // Dwell must cover mux settling plus the two sync stages
    if (DWELL < 3 || DWELL > 16) begin : g_chk
        $error("pms_mux_scan: DWELL out of range");
    end

    pms_scan_type r_reg;
    pms_scan_type r_next;

    always_comb begin
        r_next       = r_reg;
        r_next.dwell = r_reg.dwell + 4'h1;
        if (r_reg.dwell == 4'(DWELL - 1)) begin
            r_next.dwell              = 4'h0;
            r_next.inputs[r_reg.sel]  = i_serial_sync;
            r_next.sel                = r_reg.sel + 3'h1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            r_reg <= '0;
        end else if (i_ce) begin
            r_reg <= r_next;
        end
    end

    assign o_mux_select = r_reg.sel;
    assign o_pmc_inputs = r_reg.inputs;
endmodule
`default_nettype wire

// *** sim/pms_far_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module pms_far_model (
    // Clock, scan select, hold request
    input  wire logic       i_mclk,
    input  wire logic [2:0] i_mux_select,
    input  wire logic       i_hold,
    // Scenario levels
    input  wire logic       i_power_good,
    input  wire logic       i_local_request,
    input  wire logic [7:0] i_opcode,
    // Data phases seen from the device
    input  wire logic       i_high_enable_n,
    input  wire logic       i_low_enable_n,
    input  wire logic [15:0] i_wdata,
    // Toward the device
    output logic            o_serial,
    output logic            o_hlda,
    output logic      [7:0] o_bus
);
    // Input 1 power good, input 2 request, others low
    assign o_serial = (i_mux_select == 3'h1) ? i_power_good :
                      (i_mux_select == 3'h2) ? i_local_request : 1'h0;
    always_ff @(posedge i_mclk) begin
        o_hlda <= i_hold;
    end
    // Write bytes only inside the data phases, else the opcode
    assign o_bus = (!i_opcode[7] || (i_high_enable_n && i_low_enable_n)) ? i_opcode :
                   !i_high_enable_n ? i_wdata[15:8] : i_wdata[7:0];
endmodule
`default_nettype wire

// *** sim/tb_power_mgmt_sequencer.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_power_mgmt_sequencer import pms_pkg::*;;
logic i_mclk='0, i_reset_n='0, i_ce='1, i_host_wr_low='0, i_host_wr_high='0;
logic [7:0] i_host_wr_data='0, i_expansion_data_bus_in, o_expansion_data_bus_out, o_pmc_inputs;
logic i_dma_req_unmasked='0, i_irq_unmasked='0, i_nmi_unmasked='0, i_processor_clock='0;
logic i_ready='1, i_hold='0, i_interrupt_request='1, i_nmi='1, i_gate_a20='0, i_hlda;
logic i_refresh_busy='0, i_dma_busy='0, i_master_busy='0, i_local_request_enable='0;
logic i_output_update_enable='1, i_power_serial_input, o_expansion_data_bus_oe;
logic [2:0] o_mux_select;
logic [4:0] o_chip_select_code;
logic o_data_high_enable_n, o_data_low_enable_n, o_processor_reset_out, o_processor_reset_oe;
logic o_processor_clock_out, o_ready, o_hold, o_interrupt_request_out, o_nmi, o_powered_down;
pms_req_type o_reg_req;
logic [15:0] i_reg_rdata=16'hA5C3, o_pmc_outputs;
logic pg='0, lreq='0;
logic [7:0] op=8'h05;
logic [3:0] w;
int fail_count=0, checks_done=0, k;
assign w = {o_hold, o_pmc_outputs[3], o_processor_reset_out, o_powered_down};
pms_far_model far (.i_mclk(i_mclk), .i_mux_select(o_mux_select), .i_hold(o_hold),
    .i_power_good(pg), .i_local_request(lreq), .i_opcode(op),
    .i_high_enable_n(o_data_high_enable_n), .i_low_enable_n(o_data_low_enable_n),
    .i_wdata(16'h3C5A),
    .o_serial(i_power_serial_input), .o_hlda(i_hlda), .o_bus(i_expansion_data_bus_in));
pms_seq #(.PG_WAIT_CYCLES(50)) dut (.*);
initial forever #4 i_mclk = ~i_mclk;
// Processor clock at half rate: 64 rising edges span 128 cycles
always @(posedge i_mclk) i_processor_clock <= ~i_processor_clock;
task automatic tick(input int n);
    repeat (n) begin
        @(posedge i_mclk);
        #1;
    end
endtask
task automatic check(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
        fail_count++;
        $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
endtask
task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
        $display("[ PASS ]");
    else
        $display("[ FAIL ]");
    $finish;
endtask
task automatic wait_on(input int b, input logic v, input int n, output int c);
    for (c = 0; c < n && w[b] !== v; c++) tick(1);
    check(w[b], v);
    if (w[b] !== v) complete_run();
endtask
task automatic t_reset();
    tick(2);
    check(o_processor_reset_out, 16'h1);
    check(o_chip_select_code, 16'h1F);
    check(o_pmc_outputs, 16'h0);
    check(o_mux_select, 16'h0);
    i_reset_n <= '1;
    tick(2);
endtask
task automatic t_down();
    logic hit;
    hit = '0;
    i_host_wr_low <= '1;
    i_host_wr_data <= 8'h20;
    tick(1);
    i_host_wr_low <= '0;
    tick(1);
    check(o_pmc_outputs[5], 16'h1);
    repeat (4) begin
        hit |= o_chip_select_code === 5'h03 && o_expansion_data_bus_out[5] === 1'h1
               && o_expansion_data_bus_oe;
        tick(1);
    end
    check(hit, 16'h1);
    check({o_processor_clock_out, o_ready, o_hold, o_interrupt_request_out, o_nmi}, 16'h0);
    tick(8);
    check(o_processor_reset_oe, 16'h0);
endtask
task automatic t_wake();
    i_irq_unmasked <= '1;
    tick(1);
    i_irq_unmasked <= '0;
    tick(1);
    check(o_pmc_outputs[5], 16'h0);
    tick(150);
    check(o_powered_down, 16'h1);
    pg <= '1;
    wait_on(0, '0, 300, k);
    check(o_pmc_inputs[1], 16'h1);
    check({o_processor_reset_out, o_processor_reset_oe}, 16'h3);
    tick(1);
    check(o_ready, 16'h1);
    wait_on(1, '0, 200, k);
    check(k >= 124 && k <= 132, 16'h1);
endtask
task automatic grant_cycle();
    lreq <= '1;
    wait_on(3, '1, 200, k);
    wait_on(2, '1, 50, k);
    lreq <= '0;
    wait_on(2, '0, 100, k);
endtask
task automatic t_local();
    logic hi, lo;
    pms_req_type rq;
    {hi, lo} = '0;
    rq = '0;
    lreq <= '1;
    tick(80);
    check(o_hold, 16'h0);
    check(o_pmc_inputs[2], 16'h1);
    i_local_request_enable <= '1;
    grant_cycle();
    repeat (40) begin
        hi |= !o_data_high_enable_n && o_expansion_data_bus_out === 8'hA5
              && o_expansion_data_bus_oe;
        lo |= !o_data_low_enable_n && o_expansion_data_bus_out === 8'hC3
              && o_expansion_data_bus_oe;
        if (o_reg_req.valid) rq = o_reg_req;
        tick(1);
    end
    check({hi, lo}, 16'h3);
    check({rq.valid, rq.write, rq.addr, rq.bypass_lock}, 16'h20B);
endtask
task automatic t_write();
    pms_req_type rq;
    rq = '0;
    op <= 8'h85;
    grant_cycle();
    repeat (30) begin
        if (o_reg_req.valid) rq = o_reg_req;
        tick(1);
    end
    check({rq.valid, rq.write, rq.addr, rq.bypass_lock}, 16'h30B);
    check(rq.wdata, 16'h3C5A);
endtask
task automatic t_a20();
    logic hit;
    logic [15:0] n;
    hit = '0;
    n = '0;
    i_gate_a20 <= '1;
    repeat (10) begin
        hit |= o_chip_select_code === 5'h03 && o_expansion_data_bus_out[6] === 1'h1
               && o_expansion_data_bus_oe;
        tick(1);
    end
    check(hit, 16'h1);
    i_output_update_enable <= '0;
    i_gate_a20 <= '0;
    repeat (20) begin
        n += (o_chip_select_code !== 5'h1F);
        tick(1);
    end
    check(n, 16'h0);
    i_host_wr_high <= '1;
    i_host_wr_data <= 8'h81;
    tick(1);
    i_host_wr_high <= '0;
    hit = '0;
    repeat (4) begin
        hit |= o_chip_select_code === 5'h17 && o_expansion_data_bus_out === 8'h81
               && o_expansion_data_bus_oe;
        tick(1);
    end
    check(hit, 16'h1);
    check(o_pmc_outputs[15:8], 16'h81);
endtask
initial begin
    t_reset();
    t_down();
    t_wake();
    t_local();
    t_write();
    t_a20();
    complete_run();
end
endmodule
`default_nettype wire
